// ---- hdl/dsle_encoder.sv ----
`timescale 1ns/1ps
// Behaviour
// - drive led shows only the highest priority active condition
// - when displayed condition clears, next active condition shows at once
// - drive led shows one colour at a time, steady or blinking
// - latching fault blinks red; indication and inhibit hold until drive reset
// - transient fault shows solid red and releases when its cause goes
// - non-latching safe torque off active shows green double blink
// - healthy but not enabled shows slow green blink
// - limit switch shows fast green blink; motion only away from switch
// - healthy and enabled shows solid green
// - five faults latch always; six optional faults and safe torque off latch when configured
// - fieldbus run led: off, blink, single flash, on per slave state
// - fieldbus error led off when fine, blinks on configuration error
// - fieldbus error led single flash after autonomous local state change
// - fieldbus error led double flash after any watchdog timeout
// - link led on with link, flickers with traffic, off without link
// - can run led: off, blink, single flash, on per network state
// - can error led off without errors, blinks on configuration error
// - can error led single flash while error counter at warning level
// - can error led double flash after guard or heartbeat event
// - can error led steady on while controller is bus off
module dsle_encoder #(
    parameter int TICK_CYCLES = dsle_pkg::TICK_CYCLES,
    parameter int FRAME_TICKS = dsle_pkg::FRAME_TICKS,
    parameter int BLINK_TICKS = dsle_pkg::BLINK_TICKS,
    parameter int SLOW_TICKS = dsle_pkg::SLOW_TICKS,
    parameter int FAST_TICKS = dsle_pkg::FAST_TICKS,
    parameter int FLASH_TICKS = dsle_pkg::FLASH_TICKS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // drive conditions and networks
    input wire dsle_pkg::dsle_drive_cond_type drive_cond,
    input wire logic drive_reset_req,
    input wire dsle_pkg::dsle_fieldbus_type fieldbus,
    input wire dsle_pkg::dsle_can_type canbus,
    // drive control
    output logic drive_inhibit,
    output logic allow_pos_motion,
    output logic allow_neg_motion,
    // leds
    output dsle_pkg::dsle_leds_type leds
);

    localparam int NF = dsle_pkg::NUM_FAULTS;
    localparam int NL = NF + 1;

    logic [dsle_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic tick;
    logic [dsle_pkg::PHASE_W-1:0] phase;
    logic [dsle_pkg::NUM_OPTIONAL-1:0] latch_cfg;
    logic [NL-1:0] latch_en;
    logic [NL-1:0] latch_src;
    logic [NL-1:0] latched;
    logic transient;
    logic drive_reset;
    logic [dsle_pkg::NUM_EVT-1:0] events;
    logic [dsle_pkg::NUM_EVT-1:0] evt_set;
    logic [dsle_pkg::NUM_EVT-1:0] evt_clr;
    logic act_seen;
    logic act_window;
    logic wb_req;
    logic wb_wr;
    dsle_pkg::dsle_pattern_type drive_pat;
    dsle_pkg::dsle_pattern_type next_drive_pat;
    logic next_drive_red;
    dsle_pkg::dsle_pattern_type fb_err_pat;
    dsle_pkg::dsle_pattern_type can_err_pat;
    logic [31:0] next_rdata;

    // level of a pattern at a given phase of the shared frame
    function automatic logic pat_level(input dsle_pkg::dsle_pattern_type p,
                                       input logic [dsle_pkg::PHASE_W-1:0] ph);
        int n;
        logic lvl;
        n = int'(ph);
        lvl = 1'b0;
        case (p)
            dsle_pkg::pat_solid: begin
                lvl = 1'b1;
            end
            dsle_pkg::pat_blink: begin
                lvl = (n % (2 * BLINK_TICKS)) < BLINK_TICKS;
            end
            dsle_pkg::pat_slow: begin
                lvl = (n % (2 * SLOW_TICKS)) < SLOW_TICKS;
            end
            dsle_pkg::pat_fast: begin
                lvl = (n % (2 * FAST_TICKS)) < FAST_TICKS;
            end
            dsle_pkg::pat_single: begin
                lvl = n < FLASH_TICKS;
            end
            dsle_pkg::pat_double: begin
                lvl = (n < FLASH_TICKS) ||
                      ((n >= 2 * FLASH_TICKS) && (n < 3 * FLASH_TICKS));
            end
            dsle_pkg::pat_flicker: begin
                lvl = ph[0];
            end
            default: begin
                lvl = 1'b0;
            end
        endcase
        return lvl;
    endfunction

    function automatic dsle_pkg::dsle_pattern_type run_pat(
        input dsle_pkg::dsle_net_state_type s);
        dsle_pkg::dsle_pattern_type p;
        p = dsle_pkg::pat_off;
        case (s)
            dsle_pkg::net_preop: begin
                p = dsle_pkg::pat_blink;
            end
            dsle_pkg::net_safeop: begin
                p = dsle_pkg::pat_single;
            end
            dsle_pkg::net_op: begin
                p = dsle_pkg::pat_solid;
            end
            default: begin
                p = dsle_pkg::pat_off;
            end
        endcase
        return p;
    endfunction

    // shared timebase: tick pulse and frame phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt ==
                dsle_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= '0;
        end else if (tick) begin
            if (phase ==
                    dsle_pkg::PHASE_W'(FRAME_TICKS - 1)) begin
                phase <= '0;
            end else begin
                phase <= phase + 1'b1;
            end
        end
    end

    // wishbone handshake: ack one cycle after request, write at the ack edge
    assign wb_req = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_req && wb_we_i &&
        wb_ack_o && wb_sel_i[0];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (wb_adr_i == dsle_pkg::ADDR_LATCH_CFG) begin
            next_rdata[dsle_pkg::NUM_OPTIONAL-1:0] = latch_cfg;
        end else if (wb_adr_i == dsle_pkg::ADDR_STATUS) begin
            next_rdata[dsle_pkg::STAT_LATCHED_LSB +: NL] = latched;
            next_rdata[dsle_pkg::STAT_PATTERN_LSB +: 8] = drive_pat;
            next_rdata[dsle_pkg::STAT_INHIBIT] = drive_inhibit;
            next_rdata[dsle_pkg::STAT_TRANSIENT] = transient;
        end else if (wb_adr_i == dsle_pkg::ADDR_EVENT) begin
            next_rdata[dsle_pkg::NUM_EVT-1:0] = events;
        end else begin
            next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_ack_o &&
                !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latch_cfg <= dsle_pkg::LATCH_CFG_RESET;
        end else if (wb_wr &&
                wb_adr_i == dsle_pkg::ADDR_LATCH_CFG) begin
            latch_cfg <= wb_dat_i[dsle_pkg::NUM_OPTIONAL-1:0];
        end
    end

    assign drive_reset = drive_reset_req ||
        (wb_wr && wb_adr_i == dsle_pkg::ADDR_CTRL &&
        wb_dat_i[dsle_pkg::CTRL_DRIVE_RESET]);

    // fault latching: five defaults always latch, the rest by configuration
    assign latch_src = {drive_cond.safe_torque_off, drive_cond.fault};
    assign latch_en = {latch_cfg, {dsle_pkg::NUM_DEFAULT_LATCH{1'b1}}};

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latched <= '0;
        end else begin
            // a fault present at the reset edge latches again at once
            latched <= (drive_reset ? '0 : latched) |
                (latch_src & latch_en);
        end
    end

    assign transient =
        |(drive_cond.fault & ~latch_en[NF-1:0]);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            drive_inhibit <= 1'b1;
        end else begin
            drive_inhibit <= (|latched) || transient ||
                drive_cond.safe_torque_off;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            allow_pos_motion <= 1'b0;
            allow_neg_motion <= 1'b0;
        end else begin
            allow_pos_motion <= !drive_cond.pos_limit;
            allow_neg_motion <= !drive_cond.neg_limit;
        end
    end

    // drive status priority encoder
    always_comb begin
        next_drive_red = 1'b0;
        next_drive_pat = dsle_pkg::pat_solid;
        if (|latched) begin
            next_drive_red = 1'b1;
            next_drive_pat = dsle_pkg::pat_blink;
        end else if (transient) begin
            next_drive_red = 1'b1;
            next_drive_pat = dsle_pkg::pat_solid;
        end else if (drive_cond.safe_torque_off) begin
            next_drive_pat = dsle_pkg::pat_double;
        end else if (!drive_cond.enabled) begin
            next_drive_pat = dsle_pkg::pat_slow;
        end else if (drive_cond.pos_limit ||
                drive_cond.neg_limit) begin
            next_drive_pat = dsle_pkg::pat_fast;
        end else begin
            next_drive_pat = dsle_pkg::pat_solid;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            drive_pat <= dsle_pkg::pat_off;
        end else begin
            drive_pat <= next_drive_pat;
        end
    end

    // sticky network events, set wins over a write-one clear
    assign evt_set[dsle_pkg::EVT_FB_LOCAL] =
        fieldbus.local_error_evt;
    assign evt_set[dsle_pkg::EVT_FB_WDOG] = fieldbus.pdo_wdog_evt ||
        fieldbus.bus_wdog_evt || fieldbus.app_wdog_evt;
    assign evt_set[dsle_pkg::EVT_CAN_ERRCTL] = canbus.guard_evt ||
        canbus.heartbeat_evt;
    assign evt_clr = (wb_wr &&
        wb_adr_i == dsle_pkg::ADDR_EVENT) ?
        wb_dat_i[dsle_pkg::NUM_EVT-1:0] : '0;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            events <= '0;
        end else begin
            events <= (events & ~evt_clr) | evt_set;
        end
    end

    // link activity stretched over one tick for the flicker
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            act_seen <= 1'b0;
            act_window <= 1'b0;
        end else if (tick) begin
            act_seen <= fieldbus.link_activity;
            act_window <= act_seen ||
                fieldbus.link_activity;
        end else begin
            act_seen <= act_seen || fieldbus.link_activity;
        end
    end

    // error led priority, most severe first
    always_comb begin
        fb_err_pat = dsle_pkg::pat_off;
        if (events[dsle_pkg::EVT_FB_WDOG]) begin
            fb_err_pat = dsle_pkg::pat_double;
        end else if (events[dsle_pkg::EVT_FB_LOCAL]) begin
            fb_err_pat = dsle_pkg::pat_single;
        end else if (fieldbus.cfg_error) begin
            fb_err_pat = dsle_pkg::pat_blink;
        end else begin
            fb_err_pat = dsle_pkg::pat_off;
        end
    end

    always_comb begin
        can_err_pat = dsle_pkg::pat_off;
        if (canbus.bus_off) begin
            can_err_pat = dsle_pkg::pat_solid;
        end else if (events[dsle_pkg::EVT_CAN_ERRCTL]) begin
            can_err_pat = dsle_pkg::pat_double;
        end else if (canbus.warn_level) begin
            can_err_pat = dsle_pkg::pat_single;
        end else if (canbus.cfg_error) begin
            can_err_pat = dsle_pkg::pat_blink;
        end else begin
            can_err_pat = dsle_pkg::pat_off;
        end
    end

    // led outputs, registered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            leds <= '0;
        end else begin
            leds.drive_red <= next_drive_red &&
                pat_level(next_drive_pat, phase);
            leds.drive_green <= !next_drive_red &&
                pat_level(next_drive_pat, phase);
            leds.fb_run <=
                pat_level(run_pat(fieldbus.state), phase);
            leds.fb_err <= pat_level(fb_err_pat, phase);
            leds.fb_link_act <= fieldbus.link_up &&
                (!act_window || pat_level(dsle_pkg::pat_flicker, phase));
            leds.can_run <=
                pat_level(run_pat(canbus.state), phase);
            leds.can_err <= pat_level(can_err_pat, phase);
        end
    end

endmodule

// ---- hdl/dsle_pkg.sv ----
package dsle_pkg;

    // clock and shared timebase
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 50000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int TICK_CNT_W = 24;

    // pattern shapes, in ticks of the shared timebase
    localparam int FRAME_TICKS = 24;
    localparam int BLINK_TICKS = 4;
    localparam int SLOW_TICKS = 12;
    localparam int FAST_TICKS = 2;
    localparam int FLASH_TICKS = 4;
    localparam int PHASE_W = 8;

    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LATCH_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_EVENT = 8'h0c;

    // control register fields
    localparam int CTRL_DRIVE_RESET = 0;

    // latch configuration: one bit per optional fault and one for safe torque off, reset value
    localparam int NUM_FAULTS = 11;
    localparam int NUM_DEFAULT_LATCH = 5;
    localparam int NUM_OPTIONAL = 7;
    localparam logic [NUM_OPTIONAL-1:0] LATCH_CFG_RESET = 7'h00;

    // status register fields
    localparam int STAT_LATCHED_LSB = 0;
    localparam int STAT_PATTERN_LSB = 12;
    localparam int STAT_INHIBIT = 20;
    localparam int STAT_TRANSIENT = 21;

    // event register fields, sticky, write one to clear
    localparam int EVT_FB_LOCAL = 0;
    localparam int EVT_FB_WDOG = 1;
    localparam int EVT_CAN_ERRCTL = 2;
    localparam int NUM_EVT = 3;

    // display patterns, one-hot
    typedef enum logic [7:0] {
        pat_off = 8'h01,
        pat_solid = 8'h02,
        pat_blink = 8'h04,
        pat_slow = 8'h08,
        pat_fast = 8'h10,
        pat_single = 8'h20,
        pat_double = 8'h40,
        pat_flicker = 8'h80
    } dsle_pattern_type;

    // network state machine states, one-hot
    typedef enum logic [3:0] {
        net_init = 4'h1,
        net_preop = 4'h2,
        net_safeop = 4'h4,
        net_op = 4'h8
    } dsle_net_state_type;

    // faults: [4:0] short, drive temp, motor temp, feedback, following
    //         [10:5] overcurrent, overvolt, undervolt, phasing, cmd lost, wiring
    typedef struct packed {
        logic [NUM_FAULTS-1:0] fault;
        logic safe_torque_off;
        logic enabled;
        logic pos_limit;
        logic neg_limit;
    } dsle_drive_cond_type;

    typedef struct packed {
        dsle_net_state_type state;
        logic cfg_error;
        logic local_error_evt;
        logic pdo_wdog_evt;
        logic bus_wdog_evt;
        logic app_wdog_evt;
        logic link_up;
        logic link_activity;
    } dsle_fieldbus_type;

    typedef struct packed {
        dsle_net_state_type state;
        logic cfg_error;
        logic warn_level;
        logic guard_evt;
        logic heartbeat_evt;
        logic bus_off;
    } dsle_can_type;

    typedef struct packed {
        logic drive_red;
        logic drive_green;
        logic fb_run;
        logic fb_err;
        logic fb_link_act;
        logic can_run;
        logic can_err;
    } dsle_leds_type;

endpackage

// ---- verif/dsle_operator_model.sv ----
`timescale 1ns/1ps
// operator watching the leds: counts lit cycles and turn-on events per led
module dsle_operator_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // leds and counter control
    input wire dsle_pkg::dsle_leds_type leds,
    input wire logic clear,
    output logic [6:0][7:0] lit_cnt,
    output logic [6:0][7:0] rise_cnt
);
    logic [6:0] prev;
    always_ff @(posedge ref_clk) begin
        prev <= leds;
        for (int i = 0; i < 7; i++) begin
            if (sys_rst || clear) begin
                lit_cnt[i] <= 8'h00;
                rise_cnt[i] <= 8'h00;
            end else begin
                lit_cnt[i] <= lit_cnt[i] + 8'(leds[i]);
                rise_cnt[i] <= rise_cnt[i] + 8'(leds[i] & ~prev[i]);
            end
        end
    end
endmodule

// ---- verif/dsle_encoder_monitor.sv ----
`timescale 1ns/1ps
module dsle_encoder_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // conditions and outputs
    input wire dsle_pkg::dsle_drive_cond_type drive_cond,
    input wire logic drive_reset_req,
    input wire dsle_pkg::dsle_fieldbus_type fieldbus,
    input wire dsle_pkg::dsle_can_type canbus,
    input wire logic drive_inhibit,
    input wire logic allow_pos_motion,
    input wire logic allow_neg_motion,
    input wire dsle_pkg::dsle_leds_type leds
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_one_colour: assert property (!(leds.drive_red && leds.drive_green))
        else $error("drive led lit in both colours");
    a_motion_limit: assert property (!$past(sys_rst) |->
        allow_pos_motion == !$past(drive_cond.pos_limit)
        && allow_neg_motion == !$past(drive_cond.neg_limit))
        else $error("motion permit does not follow limit switch");
    a_latch_hold: assert property ((drive_cond.fault[0] && !drive_reset_req && !wb_we_i)
        ##1 (!drive_reset_req && !wb_we_i) [*3] |-> drive_inhibit && !leds.drive_green)
        else $error("latched fault not held");
    a_link_off: assert property (!$past(sys_rst) && !$past(fieldbus.link_up)
        |-> !leds.fb_link_act) else $error("link led lit without link");
    a_bus_off: assert property (!$past(sys_rst) && $past(canbus.bus_off)
        |-> leds.can_err) else $error("can error led dark while bus off");
    a_fb_run_op: assert property (!$past(sys_rst)
        && $past(fieldbus.state) == dsle_pkg::net_op |-> leds.fb_run)
        else $error("fieldbus run led dark in operational");
    a_can_run_init: assert property (!$past(sys_rst)
        && $past(canbus.state) == dsle_pkg::net_init |-> !leds.can_run)
        else $error("can run led lit in init");
    a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer not a single pulse");
endmodule
bind dsle_encoder dsle_encoder_monitor i_dsle_encoder_monitor (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .drive_cond(drive_cond), .drive_reset_req(drive_reset_req),
    .fieldbus(fieldbus), .canbus(canbus), .drive_inhibit(drive_inhibit),
    .allow_pos_motion(allow_pos_motion), .allow_neg_motion(allow_neg_motion), .leds(leds));

// ---- verif/dsle_encoder_tb.sv ----
`timescale 1ns/1ps
module dsle_encoder_tb;
    localparam int TC = 4;
    localparam int FT = dsle_pkg::FRAME_TICKS;
    localparam int F = FT * TC;
    localparam int RED = 6;
    localparam int GRN = 5;
    localparam int FBR = 4;
    localparam int FBE = 3;
    localparam int LNK = 2;
    localparam int CNR = 1;
    localparam int CNE = 0;
    localparam dsle_pkg::dsle_pattern_type RUN_PAT [4] = '{dsle_pkg::pat_off,
        dsle_pkg::pat_blink, dsle_pkg::pat_single, dsle_pkg::pat_solid};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    dsle_pkg::dsle_drive_cond_type drive_cond = '0;
    logic drive_reset_req = 1'b0;
    dsle_pkg::dsle_fieldbus_type fieldbus = '0;
    dsle_pkg::dsle_can_type canbus = '0;
    logic drive_inhibit;
    logic allow_pos_motion;
    logic allow_neg_motion;
    dsle_pkg::dsle_leds_type leds;
    logic clear = 1'b0;
    logic [6:0][7:0] lit_cnt;
    logic [6:0][7:0] rise_cnt;
    logic [6:0][7:0] lit;
    logic [6:0][7:0] rise;
    logic [31:0] q;
    int miscompares = 0;
    int checks_done = 0;

    always #2 ref_clk = ~ref_clk;

    dsle_encoder #(.TICK_CYCLES(TC)) i_dsle_encoder (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .drive_cond(drive_cond), .drive_reset_req(drive_reset_req), .fieldbus(fieldbus),
        .canbus(canbus), .drive_inhibit(drive_inhibit), .allow_pos_motion(allow_pos_motion),
        .allow_neg_motion(allow_neg_motion), .leds(leds));

    dsle_operator_model i_dsle_operator_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .leds(leds), .clear(clear), .lit_cnt(lit_cnt), .rise_cnt(rise_cnt));

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= sel;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (wb_ack_o !== 1'b1) miscompares++;
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_sel <= 4'h0;
        @(posedge ref_clk);
    endtask

    // lit cycles and turn-ons over one frame for each pattern
    function automatic logic [15:0] shape(input dsle_pkg::dsle_pattern_type p);
        case (p)
            dsle_pkg::pat_solid: return {8'(F), 8'h00};
            dsle_pkg::pat_blink: return {8'(F / 2), 8'(FT / (2 * dsle_pkg::BLINK_TICKS))};
            dsle_pkg::pat_slow: return {8'(F / 2), 8'(FT / (2 * dsle_pkg::SLOW_TICKS))};
            dsle_pkg::pat_fast: return {8'(F / 2), 8'(FT / (2 * dsle_pkg::FAST_TICKS))};
            dsle_pkg::pat_single: return {8'(dsle_pkg::FLASH_TICKS * TC), 8'h01};
            dsle_pkg::pat_double: return {8'(2 * dsle_pkg::FLASH_TICKS * TC), 8'h02};
            dsle_pkg::pat_flicker: return {8'(F / 2), 8'(FT / 2)};
            default: return 16'h0000;
        endcase
    endfunction

    task automatic measure();
        repeat (2 * TC) @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        repeat (F) @(posedge ref_clk);
        #1;
        lit = lit_cnt;
        rise = rise_cnt;
        @(posedge ref_clk);
    endtask

    task automatic see(input string what, input int i, input dsle_pkg::dsle_pattern_type p);
        check(what, {16'h0000, lit[i], rise[i]}, {16'h0000, shape(p)});
    endtask

    task automatic step(input dsle_pkg::dsle_pattern_type p, input int on, input int off);
        measure();
        wb(1'b0, dsle_pkg::ADDR_STATUS, 32'h0);
        check("shown pattern", {24'h0, q[19:12]}, {24'h0, p});
        see("drive led lit", on, p);
        see("drive led dark", off, dsle_pkg::pat_off);
    endtask

    task automatic t_regs();
        wb(1'b0, dsle_pkg::ADDR_LATCH_CFG, 32'h0);
        check("latch cfg reset", q, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        check("unmapped read", q, 32'h0);
        wb(1'b1, dsle_pkg::ADDR_STATUS, 32'hffffffff);
        step(dsle_pkg::pat_solid, GRN, RED);
    endtask

    task automatic t_priority();
        drive_cond.fault[5] <= 1'b1;
        drive_cond.safe_torque_off <= 1'b1;
        drive_cond.enabled <= 1'b0;
        drive_cond.pos_limit <= 1'b1;
        step(dsle_pkg::pat_solid, RED, GRN);
        check("inhibit", {31'h0, drive_inhibit}, 32'h1);
        drive_cond.fault[5] <= 1'b0;
        step(dsle_pkg::pat_double, GRN, RED);
        drive_cond.safe_torque_off <= 1'b0;
        step(dsle_pkg::pat_slow, GRN, RED);
        check("inhibit", {31'h0, drive_inhibit}, 32'h0);
        drive_cond.enabled <= 1'b1;
        step(dsle_pkg::pat_fast, GRN, RED);
        check("allow", {30'h0, allow_pos_motion, allow_neg_motion}, 32'h1);
        drive_cond.pos_limit <= 1'b0;
        step(dsle_pkg::pat_solid, GRN, RED);
    endtask

    task automatic t_latch();
        drive_cond.fault[0] <= 1'b1;
        @(posedge ref_clk);
        drive_cond.fault[0] <= 1'b0;
        step(dsle_pkg::pat_blink, RED, GRN);
        check("inhibit", {31'h0, drive_inhibit}, 32'h1);
        wb(1'b1, dsle_pkg::ADDR_CTRL, 32'h1);
        step(dsle_pkg::pat_solid, GRN, RED);
        sel = 4'he;
        wb(1'b1, dsle_pkg::ADDR_LATCH_CFG, 32'h7f);
        sel = 4'hf;
        wb(1'b0, dsle_pkg::ADDR_LATCH_CFG, 32'h0);
        check("masked write", q, 32'h0);
        wb(1'b1, dsle_pkg::ADDR_LATCH_CFG, 32'h1);
        wb(1'b0, dsle_pkg::ADDR_LATCH_CFG, 32'h0);
        check("latch cfg", q, 32'h1);
        drive_cond.fault[5] <= 1'b1;
        @(posedge ref_clk);
        drive_cond.fault[5] <= 1'b0;
        step(dsle_pkg::pat_blink, RED, GRN);
        drive_reset_req <= 1'b1;
        @(posedge ref_clk);
        drive_reset_req <= 1'b0;
        step(dsle_pkg::pat_solid, GRN, RED);
    endtask

    task automatic t_run();
        for (int i = 0; i < 4; i++) begin
            fieldbus.state <= dsle_pkg::dsle_net_state_type'(4'h1 << i);
            canbus.state <= dsle_pkg::dsle_net_state_type'(4'h1 << i);
            measure();
            see("fieldbus run", FBR, RUN_PAT[i]);
            see("can run", CNR, RUN_PAT[i]);
        end
    endtask

    task automatic t_err();
        fieldbus.cfg_error <= 1'b1;
        canbus.cfg_error <= 1'b1;
        measure();
        see("fieldbus error", FBE, dsle_pkg::pat_blink);
        see("can error", CNE, dsle_pkg::pat_blink);
        fieldbus.local_error_evt <= 1'b1;
        canbus.warn_level <= 1'b1;
        @(posedge ref_clk);
        fieldbus.local_error_evt <= 1'b0;
        measure();
        see("fieldbus error", FBE, dsle_pkg::pat_single);
        see("can error", CNE, dsle_pkg::pat_single);
        wb(1'b0, dsle_pkg::ADDR_EVENT, 32'h0);
        check("events", q, 32'h1);
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, dsle_pkg::ADDR_EVENT, 32'h7);
            {fieldbus.pdo_wdog_evt, fieldbus.bus_wdog_evt, fieldbus.app_wdog_evt} <= 3'h4 >> k;
            {canbus.guard_evt, canbus.heartbeat_evt} <= 2'h2 >> k;
            @(posedge ref_clk);
            {fieldbus.pdo_wdog_evt, fieldbus.bus_wdog_evt, fieldbus.app_wdog_evt} <= 3'h0;
            {canbus.guard_evt, canbus.heartbeat_evt} <= 2'h0;
            measure();
            see("fieldbus error", FBE, dsle_pkg::pat_double);
            if (k < 2) see("can error", CNE, dsle_pkg::pat_double);
            else see("can error", CNE, dsle_pkg::pat_single);
        end
        wb(1'b1, dsle_pkg::ADDR_EVENT, 32'h7);
        fieldbus.cfg_error <= 1'b0;
        canbus.cfg_error <= 1'b0;
        canbus.warn_level <= 1'b0;
        measure();
        see("fieldbus error", FBE, dsle_pkg::pat_off);
        see("can error", CNE, dsle_pkg::pat_off);
        canbus.bus_off <= 1'b1;
        measure();
        see("can error", CNE, dsle_pkg::pat_solid);
        canbus.bus_off <= 1'b0;
    endtask

    task automatic t_link();
        measure();
        see("link", LNK, dsle_pkg::pat_off);
        fieldbus.link_up <= 1'b1;
        measure();
        see("link", LNK, dsle_pkg::pat_solid);
        fieldbus.link_activity <= 1'b1;
        measure();
        see("link", LNK, dsle_pkg::pat_flicker);
    endtask

    initial begin
        #100000;
        miscompares++;
        stop_test();
    end

    initial begin
        fieldbus.state = dsle_pkg::net_init;
        canbus.state = dsle_pkg::net_init;
        drive_cond.enabled = 1'b1;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_priority();
        t_latch();
        t_run();
        t_err();
        t_link();
        stop_test();
    end
endmodule
